// ===== logic/tag_regs.sv
// APB register bank with tasks, events, shortcuts and interrupt enables of the tag peripheral
// Operation
// [RULE_01] Activation trigger write of one moves tag to activated state.
// [RULE_02] Sense trigger write of one enters field-sensing state.
// [RULE_03] Transmit trigger write of one starts a frame, enters transmit state; here the state does not change when the tag is disabled or sensing.
// [RULE_04] Receive-arm trigger write of one arms receive transfer; reads zero.
// [RULE_05] Idle trigger write of one forces idle state.
// [RULE_06] Sleep trigger write of one forces first sleep state.
// [RULE_07] Ready flag set when tag can handle frames; bit 0 holds each flag.
// [RULE_08] Field-detected flag set when reader field appears.
// [RULE_09] Field-lost flag set when reader field disappears.
// [RULE_10] Transmit-frame-start flag set at first symbol of each sent frame.
// [RULE_11] Transmit-frame-end flag set after last on-air symbol.
// [RULE_12] Receive-frame-start flag set after first received symbol.
// [RULE_13] Receive-frame-end flag set after checks, storage and buffer release.
// [RULE_14] Error flag set on any error; cause kept in fault status.
// [RULE_15] Receive-fault flag set on faulty frame; cause kept in frame status.
// [RULE_16] Receive-buffer-full flag set when buffer completely filled.
// [RULE_17] Transmit-done flag set once transmit buffer released.
// [RULE_18] Anticollision start, fault and done each raise own flag.
// [RULE_19] Transfer-started flag set when transfer engine is ready.
// [RULE_20] Shortcut register: bits 0, 1, 5 link events to tasks; reset zero.
// [RULE_21] Interrupt mask holds one bit per event at listed positions; reset zero.
// [RULE_22] Disable trigger switches tag off until activated or sensing again; here idle and sleep triggers also move it out of the off state.
//
// Chosen here: the APB register port.
`default_nettype none
module tag_regs #(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [tag_pkg::NUM_EVT-1:0] engine_evt_in,
	input wire logic field_present_in,
	output tag_pkg::tag_task_s task_out,
	output logic [5:0] tag_state_out,
	output logic [tag_pkg::NUM_EVT-1:0] evt_irq_enabled_out
);
	tag_pkg::tag_apb_req_s req;
	tag_pkg::tag_state_e state;
	tag_pkg::tag_state_e next_state;
	tag_pkg::tag_task_s next_task;
	logic [31:0] event_task_links;
	logic [31:0] irq_mask;
	logic [tag_pkg::NUM_EVT-1:0] flags;
	logic [tag_pkg::NUM_EVT-1:0] evt_hit;
	logic [tag_pkg::NUM_EVT-1:0] evt_wr_en;
	logic [tag_pkg::NUM_EVT-1:0] evt_wr_val;
	logic [tag_pkg::NUM_EVT-1:0] hw_set;
	logic [tag_pkg::NUM_EVT-1:0] masked_en;
	logic [1:0] field_sync;
	logic field_seen;
	logic field_rise;
	logic field_fall;
	logic setup_phase;
	logic wr_fire;
	logic rd_fire;
	logic wr_one;
	logic hit_task;
	logic hit_evt;
	logic hit_links;
	logic hit_mask;
	logic hit_state;
	logic mapped;
	logic evt_rd_bit;
	logic [31:0] rd_mux;
	logic [31:0] next_links;
	logic [31:0] next_mask;
	logic short_activate;
	logic short_sense;
	logic short_rx_arm;
	logic set_field_on;
	logic set_field_off;
	logic set_ready;
	logic trig_wr;
	logic wr_activate;
	logic wr_shutdown;
	logic wr_sense;
	logic wr_transmit;
	logic wr_rx_arm;
	logic wr_idle;
	logic wr_sleep;

	// Whole-word write with byte strobes merged into the old value
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] strb, input logic [31:0] wmask);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_val[8*i +: 8];
			end
		end
		return res & wmask;
	endfunction

	// Address compare on the word offset
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		return a[11:0] == ofs;
	endfunction

	assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in, addr: paddr_in[11:0], wdata: pwdata_in};

	// Slave answers on the second access cycle so every access takes exactly setup plus two
	assign setup_phase = req.sel && !req.enable;
	assign wr_fire = req.sel && req.enable && pready_out && req.write;
	assign rd_fire = req.sel && req.enable && !pready_out && !req.write;
	assign wr_one = req.wdata[tag_pkg::TRIG_BIT] && pstrb_in[0];

	// Address decode
	assign hit_task = addr_is(paddr_in, tag_pkg::OFS_TRIG_ACTIVATE) || addr_is(paddr_in, tag_pkg::OFS_TRIG_SHUTDOWN)
		|| addr_is(paddr_in, tag_pkg::OFS_TRIG_FIELD_SENSE) || addr_is(paddr_in, tag_pkg::OFS_TRIG_TRANSMIT)
		|| addr_is(paddr_in, tag_pkg::OFS_TRIG_RX_ARM) || addr_is(paddr_in, tag_pkg::OFS_TRIG_FORCE_IDLE)
		|| addr_is(paddr_in, tag_pkg::OFS_TRIG_FORCE_SLEEP);
	assign hit_evt = |evt_hit;
	assign hit_links = addr_is(paddr_in, tag_pkg::OFS_EVENT_TASK_LINKS);
	assign hit_mask = addr_is(paddr_in, tag_pkg::OFS_IRQ_MASK);
	assign hit_state = addr_is(paddr_in, tag_pkg::OFS_TAG_STATE);
	assign mapped = hit_task || hit_evt || hit_links || hit_mask || hit_state;

	// Per-event decode, write strobe and read selection
	always_comb begin
		evt_rd_bit = 1'b0;
		for (int i = 0; i < tag_pkg::NUM_EVT; i++) begin
			evt_hit[i] = addr_is(paddr_in, tag_pkg::EVT_OFS[i]);
			evt_wr_en[i] = evt_hit[i] && wr_fire && pstrb_in[0];
			evt_wr_val[i] = req.wdata[tag_pkg::TRIG_BIT];
			masked_en[i] = irq_mask[tag_pkg::EVT_MASK_BIT[i]];
			if (evt_hit[i]) begin
				evt_rd_bit = flags[i];
			end
		end
	end

	// Read mux: trigger registers read as zero, reserved bits read as zero
	// [RULE_04] triggers read zero
	assign rd_mux = hit_evt ? {31'h0000_0000, evt_rd_bit} :
		hit_links ? event_task_links :
		hit_mask ? irq_mask :
		hit_state ? {26'h000_0000, state} : tag_pkg::RESET_ZERO;

	// Field level passes two flops before use; only the second stage is observed
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			field_sync <= 2'h0;
			field_seen <= 1'b0;
		end else begin
			field_sync <= {field_sync[0], field_present_in};
			field_seen <= field_sync[1];
		end
	end
	// [RULE_08] field appears
	assign field_rise = field_sync[1] && !field_seen;
	// [RULE_09] field disappears
	assign field_fall = !field_sync[1] && field_seen;

	// Field edge sources; kept apart from hw_set so the shortcuts never loop through the state logic
	// [RULE_08] field-detected source
	assign set_field_on = engine_evt_in[tag_pkg::E_FIELD_ON] || field_rise;
	// [RULE_09] field-lost source
	assign set_field_off = engine_evt_in[tag_pkg::E_FIELD_OFF] || field_fall;
	// [RULE_07] ready on entering activated
	assign set_ready = engine_evt_in[tag_pkg::E_READY]
		|| (next_state == tag_pkg::TAG_ACTIVATED && state != tag_pkg::TAG_ACTIVATED);

	// Shortcuts from events to tasks
	// [RULE_20] field-detected to activation
	assign short_activate = event_task_links[tag_pkg::LINK_FIELD_TO_ACTIVATION] && set_field_on;
	// [RULE_20] field-lost to sensing
	assign short_sense = event_task_links[tag_pkg::LINK_LOSS_TO_SENSING] && set_field_off;
	// [RULE_20] frame end to receive arm
	assign short_rx_arm = event_task_links[tag_pkg::LINK_TXEND_TO_RX_ARM] && engine_evt_in[tag_pkg::E_TX_FINISH];

	// Event sources: engine strobes plus the locally detected field edges and the entry into activated
	always_comb begin
		hw_set = engine_evt_in;
		// [RULE_08] field-detected flag
		hw_set[tag_pkg::E_FIELD_ON] = set_field_on;
		// [RULE_09] field-lost flag
		hw_set[tag_pkg::E_FIELD_OFF] = set_field_off;
		// [RULE_07] ready flag
		hw_set[tag_pkg::E_READY] = set_ready;
	end

	// Software trigger strobes; a written zero leaves every task untouched
	assign trig_wr = wr_fire && wr_one;
	assign wr_activate = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_ACTIVATE);
	assign wr_shutdown = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_SHUTDOWN);
	assign wr_sense = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_FIELD_SENSE);
	assign wr_transmit = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_TRANSMIT);
	assign wr_rx_arm = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_RX_ARM);
	assign wr_idle = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_FORCE_IDLE);
	assign wr_sleep = trig_wr && addr_is(paddr_in, tag_pkg::OFS_TRIG_FORCE_SLEEP);

	// Task pulses from software writes or shortcuts
	always_comb begin
		// [RULE_01] activation trigger
		next_task.activate = wr_activate || short_activate;
		// [RULE_22] disable trigger
		next_task.shutdown = wr_shutdown;
		// [RULE_02] sense trigger
		next_task.sense = wr_sense || short_sense;
		// [RULE_03] transmit trigger
		next_task.transmit = wr_transmit;
		// [RULE_04] receive arm trigger
		next_task.rx_arm = wr_rx_arm || short_rx_arm;
		// [RULE_05] idle trigger
		next_task.force_idle = wr_idle;
		// [RULE_06] sleep trigger
		next_task.force_sleep = wr_sleep;
	end

	// State machine; later lines win so disable beats any other same-cycle task
	always_comb begin
		next_state = state;
		unique case (state)
			tag_pkg::TAG_TRANSMIT: begin
				// Frame end returns to activated
				if (engine_evt_in[tag_pkg::E_TX_FINISH]) begin
					next_state = tag_pkg::TAG_ACTIVATED;
				end
			end
			tag_pkg::TAG_DISABLED, tag_pkg::TAG_SENSE, tag_pkg::TAG_ACTIVATED, tag_pkg::TAG_IDLE,
			tag_pkg::TAG_SLEEP: begin
				next_state = state;
			end
			default: begin
				next_state = tag_pkg::TAG_DISABLED;
			end
		endcase
		// [RULE_03] transmit state only from a live tag
		if (next_task.transmit && state != tag_pkg::TAG_DISABLED && state != tag_pkg::TAG_SENSE) begin
			next_state = tag_pkg::TAG_TRANSMIT;
		end
		// [RULE_05] idle state
		if (next_task.force_idle) begin
			next_state = tag_pkg::TAG_IDLE;
		end
		// [RULE_06] first sleep state
		if (next_task.force_sleep) begin
			next_state = tag_pkg::TAG_SLEEP;
		end
		// [RULE_01] activated state
		if (next_task.activate) begin
			next_state = tag_pkg::TAG_ACTIVATED;
		end
		// [RULE_02] sense state
		if (next_task.sense) begin
			next_state = tag_pkg::TAG_SENSE;
		end
		// [RULE_22] switched off
		if (next_task.shutdown) begin
			next_state = tag_pkg::TAG_DISABLED;
		end
	end

	// Shortcut and mask writes keep only the implemented bits
	// [RULE_20] three link bits
	assign next_links = merge_bytes(event_task_links, req.wdata, pstrb_in, tag_pkg::LINKS_WMASK);
	// [RULE_21] mask bit layout
	assign next_mask = merge_bytes(irq_mask, req.wdata, pstrb_in, tag_pkg::IRQ_MASK_WMASK);

	// Configuration registers
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			event_task_links <= tag_pkg::RESET_ZERO;
			irq_mask <= tag_pkg::RESET_ZERO;
		end else if (wr_fire && hit_links) begin
			event_task_links <= next_links;
		end else if (wr_fire && hit_mask) begin
			irq_mask <= next_mask;
		end
	end

	// State and task pulse registers
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= tag_pkg::TAG_DISABLED;
			task_out <= '0;
		end else begin
			state <= next_state;
			task_out <= next_task;
		end
	end

	// APB answer: pready rises one cycle into the access phase, read data registered with it
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= tag_pkg::RESET_ZERO;
		end else if (req.sel && req.enable && !pready_out) begin
			pready_out <= 1'b1;
			pslverr_out <= !mapped;
			prdata_out <= rd_fire ? rd_mux : tag_pkg::RESET_ZERO;
		end else begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= setup_phase ? tag_pkg::RESET_ZERO : prdata_out;
		end
	end

	// Mirrors of state and of which events may interrupt
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tag_state_out <= tag_pkg::TAG_DISABLED;
			evt_irq_enabled_out <= '0;
		end else begin
			tag_state_out <= next_state;
			evt_irq_enabled_out <= masked_en;
		end
	end

	// Sticky event flags; engine strobes carry rules 10 to 19 timing
	// [RULE_10] transmit start flag
	// [RULE_11] transmit end flag
	// [RULE_12] receive start flag
	// [RULE_13] frame-end only as strobed after buffer release
	// [RULE_14] general fault flag
	// [RULE_15] receive fault flag
	// [RULE_16] buffer full flag
	// [RULE_17] transmit done flag
	// [RULE_18] anticollision flags
	// [RULE_19] transfer ready flag
	tag_event_flags #(
		.WIDTH(tag_pkg::NUM_EVT)
	) u_flags (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.set_in(hw_set),
		.wr_en_in(evt_wr_en),
		.wr_val_in(evt_wr_val),
		.flags_out(flags)
	);
endmodule // tag_regs
`default_nettype wire

// ===== logic/tag_pkg.sv
// Package with register map, field layout and state encodings of the tag task/event block
`default_nettype none
package tag_pkg;
	localparam logic [11:0] OFS_TRIG_ACTIVATE = 12'h000;
	localparam logic [11:0] OFS_TRIG_SHUTDOWN = 12'h004;
	localparam logic [11:0] OFS_TRIG_FIELD_SENSE = 12'h008;
	localparam logic [11:0] OFS_TRIG_TRANSMIT = 12'h00C;
	localparam logic [11:0] OFS_TRIG_RX_ARM = 12'h01C;
	localparam logic [11:0] OFS_TRIG_FORCE_IDLE = 12'h024;
	localparam logic [11:0] OFS_TRIG_FORCE_SLEEP = 12'h028;
	localparam logic [11:0] OFS_EVT_BASE = 12'h100;
	localparam logic [11:0] OFS_EVENT_TASK_LINKS = 12'h200;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h300;
	localparam logic [11:0] OFS_TAG_STATE = 12'h410;

	localparam int NUM_EVT = 15;
	localparam int EVT_IDX_W = 4;
	// Event offsets, in slot order
	localparam logic [11:0] EVT_OFS [NUM_EVT] = '{12'h100, 12'h104, 12'h108, 12'h10C, 12'h110, 12'h114,
		12'h118, 12'h11C, 12'h128, 12'h12C, 12'h130, 12'h138, 12'h148, 12'h14C, 12'h150};
	// Interrupt mask bit used by each event slot
	localparam int EVT_MASK_BIT [NUM_EVT] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 14, 18, 19, 20};

	localparam int E_READY = 0;
	localparam int E_FIELD_ON = 1;
	localparam int E_FIELD_OFF = 2;
	localparam int E_TX_BEGIN = 3;
	localparam int E_TX_FINISH = 4;
	localparam int E_RX_BEGIN = 5;
	localparam int E_RX_FINISH = 6;
	localparam int E_FAULT = 7;
	localparam int E_RX_FAULT = 8;
	localparam int E_RX_FULL = 9;
	localparam int E_TX_DONE = 10;
	localparam int E_AC_BEGIN = 11;
	localparam int E_AC_FAULT = 12;
	localparam int E_AC_DONE = 13;
	localparam int E_XFER_READY = 14;

	localparam int LINK_FIELD_TO_ACTIVATION = 0;
	localparam int LINK_LOSS_TO_SENSING = 1;
	localparam int LINK_TXEND_TO_RX_ARM = 5;
	localparam logic [31:0] LINKS_WMASK = 32'h0000_0023;
	localparam logic [31:0] IRQ_MASK_WMASK = 32'h001C_5CFF;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
	localparam int TRIG_BIT = 0;

	// One-hot tag states
	typedef enum logic [5:0] {
		TAG_DISABLED = 6'h01,
		TAG_SENSE = 6'h02,
		TAG_ACTIVATED = 6'h04,
		TAG_TRANSMIT = 6'h08,
		TAG_IDLE = 6'h10,
		TAG_SLEEP = 6'h20
	} tag_state_e;

	// Task pulses toward the protocol engine
	typedef struct packed {
		logic activate;
		logic shutdown;
		logic sense;
		logic transmit;
		logic rx_arm;
		logic force_idle;
		logic force_sleep;
	} tag_task_s;

	// APB request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} tag_apb_req_s;
endpackage
`default_nettype wire

// ===== logic/tag_event_flags.sv
// Sticky event flag bank, hardware set wins over software clear
`default_nettype none
module tag_event_flags #(
	parameter int WIDTH = 15
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] wr_en_in,
	input wire logic [WIDTH-1:0] wr_val_in,
	output logic [WIDTH-1:0] flags_out
);
	logic [WIDTH-1:0] next_flags;

	// Write stores the value; a same-cycle hardware set still wins
	assign next_flags = (flags_out & ~wr_en_in) | (wr_val_in & wr_en_in) | set_in;

	// Flags storage
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= '0;
		end else begin
			flags_out <= next_flags;
		end
	end
endmodule // tag_event_flags
`default_nettype wire

// ===== verif/tag_regs_chk.sv
// Port-level assertion checker for the tag register bank
`default_nettype none
module tag_regs_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [tag_pkg::NUM_EVT-1:0] engine_evt_in,
	input wire logic field_present_in,
	input wire tag_pkg::tag_task_s task_out,
	input wire logic [5:0] tag_state_out,
	input wire logic [tag_pkg::NUM_EVT-1:0] evt_irq_enabled_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	// Bus handshake: answer one cycle into the access phase, one cycle wide
	a_ready_after_access: assert property ($rose(psel_in && penable_in) |=> pready_out) else $error("pready late");
	a_ready_one_cycle: assert property (pready_out |=> !pready_out) else $error("pready too long");
	a_ready_has_cause: assert property (pready_out |-> psel_in && penable_in) else $error("pready unasked");
	a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("pslverr alone");
	a_state_onehot: assert property ($onehot(tag_state_out)) else $error("state not one-hot");
	// Each shutdown, sense, activate, sleep and idle task pulse lands the state machine in its state, by priority
	a_shutdown_state: assert property (task_out.shutdown |-> tag_state_out == 6'h01) else $error("off");
	a_sense_state: assert property (task_out.sense && !task_out.shutdown |-> tag_state_out == 6'h02)
		else $error("sense");
	a_activate_state: assert property (task_out.activate && !task_out.shutdown && !task_out.sense
		|-> tag_state_out == 6'h04) else $error("activate");
	a_sleep_state: assert property (task_out.force_sleep && !(task_out.shutdown || task_out.sense
		|| task_out.activate) |-> tag_state_out == 6'h20) else $error("sleep");
	a_idle_state: assert property (task_out.force_idle && !(task_out.shutdown || task_out.sense
		|| task_out.activate || task_out.force_sleep) |-> tag_state_out == 6'h10) else $error("idle");
	a_arm_reads_zero: assert property (pready_out && !pwrite_in && paddr_in == 12'h01C
		|-> prdata_out == 32'h0000_0000) else $error("arm trigger readable");
endmodule // tag_regs_chk
bind tag_regs tag_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .engine_evt_in(engine_evt_in),
	.field_present_in(field_present_in), .task_out(task_out), .tag_state_out(tag_state_out),
	.evt_irq_enabled_out(evt_irq_enabled_out));
`default_nettype wire

// ===== verif/tb_nfc_tag_task_event_regs.sv
// Self-checking bench for the tag register bank over APB
`default_nettype none
module tb_nfc_tag_task_event_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, field_on = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, rd_err;
	logic [14:0] evt = 15'h0000, irq_en;
	logic [5:0] state;
	tag_pkg::tag_task_s tasks;
	int err_total = 0, checks_done = 0, arm_cnt = 0, n;
	// Trigger offsets and the state each one must reach, in order
	logic [11:0] t_ofs [8] = '{12'h008, 12'h000, 12'h00C, 12'h024, 12'h028, 12'h004, 12'h00C, 12'h01C};
	logic [5:0] t_st [8] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01, 6'h01, 6'h01};

	tag_regs dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .engine_evt_in(evt), .field_present_in(field_on),
		.task_out(tasks), .tag_state_out(state), .evt_irq_enabled_out(irq_en));

	// Free-running 100 MHz clock
	initial forever #5 sys_clk_in = ~sys_clk_in;
	// Receive-arm pulses are counted since they leave no state behind
	always @(posedge sys_clk_in) if (tasks.rx_arm === 1'b1) arm_cnt++;

	task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; held until pready is sampled high at a rising edge, released at that edge
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		do @(posedge sys_clk_in); while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check_eq(rd, exp);
	endtask
	task automatic pulse(input int i);
		@(posedge sys_clk_in);
		evt[i] <= 1'b1;
		@(posedge sys_clk_in);
		evt[i] <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Cut a hang short well past the expected run length
	initial begin
		#200us;
		err_total++;
		give_verdict();
	end

	initial begin
		repeat (5) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_chk(12'h200, 32'h0);
		rd_chk(12'h300, 32'h0);
		rd_chk(12'h01C, 32'h0);
		check_eq(32'(state), 32'h01);
		// Only the documented enable bits can be set
		xfer(1'b1, 12'h200, 32'hFFFF_FFFF);
		rd_chk(12'h200, 32'h0000_0023);
		xfer(1'b1, 12'h300, 32'hFFFF_FFFF);
		rd_chk(12'h300, 32'h001C_5CFF);
		xfer(1'b1, 12'h200, 32'h0);
		// Unmapped place: error response, read bits 31:1 zero
		xfer(1'b0, 12'h0F0, 32'h0);
		check_eq({rd[31:1], rd_err}, 32'h1);
		// Every event: mask bit maps to its slot, flag sets, software clears
		for (int i = 0; i < tag_pkg::NUM_EVT; i++) begin
			xfer(1'b1, 12'h300, 32'h1 << tag_pkg::EVT_MASK_BIT[i]);
			pulse(i);
			rd_chk(tag_pkg::EVT_OFS[i], 32'h1);
			check_eq(32'(irq_en), 32'h1 << i);
			xfer(1'b1, tag_pkg::EVT_OFS[i], 32'h0);
			rd_chk(tag_pkg::EVT_OFS[i], 32'h0);
		end
		// Writing zero to a trigger does nothing
		xfer(1'b1, 12'h000, 32'h0);
		@(negedge sys_clk_in);
		check_eq(32'(state), 32'h01);
		// Trigger table, transmit from disabled is ignored
		n = arm_cnt;
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, t_ofs[i], 32'h1);
			@(negedge sys_clk_in);
			check_eq(32'(state), 32'(t_st[i]));
			rd_chk(12'h410, 32'(t_st[i]));
		end
		check_eq(32'(arm_cnt), 32'(n + 1));
		// Shortcuts: field appears activates, field lost senses, frame end arms
		xfer(1'b1, 12'h200, 32'h0000_0023);
		field_on <= 1'b1;
		repeat (10) @(posedge sys_clk_in);
		check_eq(32'(state), 32'h04);
		rd_chk(12'h104, 32'h1);
		field_on <= 1'b0;
		repeat (10) @(posedge sys_clk_in);
		check_eq(32'(state), 32'h02);
		rd_chk(12'h108, 32'h1);
		n = arm_cnt;
		pulse(tag_pkg::E_TX_FINISH);
		repeat (3) @(posedge sys_clk_in);
		check_eq(32'(arm_cnt), 32'(n + 1));
		give_verdict();
	end
endmodule // tb_nfc_tag_task_event_regs
`default_nettype wire
